/* urx_sync.sv */
// constants package and input synchroniser for the serial receive front end
`timescale 1ns/100ps
`default_nettype none

package urx_pkg;
  // ----------------------------------------------------------------
  // oversampling and voting positions
  // ----------------------------------------------------------------
  localparam logic [4:0] NORMAL_SPB = 5'h10; // samples per bit, normal mode
  localparam logic [4:0] DOUBLE_SPB = 5'h08; // samples per bit, double speed
  localparam logic [4:0] NORMAL_VOTE_FIRST = 5'h08;
  localparam logic [4:0] DOUBLE_VOTE_FIRST = 5'h04;
  localparam logic [4:0] VOTE_SPAN = 5'h02; // last vote sample minus first
  localparam logic [4:0] FIRST_SAMPLE = 5'h01;
  // ----------------------------------------------------------------
  // frame size limits and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] MIN_FRAME_BITS = 4'h5;
  localparam logic [3:0] MAX_FRAME_BITS = 4'hA;
  localparam int DIVISOR_WIDTH = 12;
  localparam int DATA_WIDTH = 10;
  localparam logic LINE_IDLE = 1'b1;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b10,
    ST_STOP = 2'b11
  } urx_state_type;
endpackage : urx_pkg

module urx_sync (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // asynchronous line in, synchronised line out
  input wire logic i_line,
  output logic o_line
);
  logic meta;
  logic next_meta;
  logic next_line;

  // two stages; the line idles high so reset to the idle level
  always_comb begin
    next_meta = i_line;
    next_line = meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= urx_pkg::LINE_IDLE;
      o_line <= urx_pkg::LINE_IDLE;
    end else begin
      meta <= next_meta;
      o_line <= next_line;
    end
  end
endmodule : urx_sync

`default_nettype wire

/* urx_recovery.sv */
// asynchronous receive clock and data recovery with majority voting
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - sample at 16x baud, 8x in double speed
// - falling edge while idle starts detection, sample one
// - start qualified by samples 8-10 or 4-6
// - majority high start means noise, resume search
// - realign bit timing on every valid start
// - per-bit counter of 16 or 8 states
// - bit value is majority of three samples
// - vote window from sample 8 or 4
// - recover through first stop bit, ignore others
// - stop voting zero sets frame error flag
// - next start edge seen right after stop vote
// - data plus parity length five to ten bits
// - frame error travels with its frame
// - double speed divides final stage by eight
module urx_recovery (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // serial line and configuration
  input wire logic i_rx_line,
  input wire logic i_double_speed_select,
  input wire logic [11:0] i_baud_divisor_value,
  input wire logic [3:0] i_frame_bits,
  // recovered frame towards the buffer logic
  output logic o_frame_valid,
  output logic [9:0] o_frame_data,
  output logic o_frame_error_flag,
  output logic o_busy
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : majority

  // out-of-range sizes are clamped so the frame always terminates
  function automatic logic [3:0] clamp_bits(input logic [3:0] n);
    if (n < urx_pkg::MIN_FRAME_BITS) begin
      clamp_bits = urx_pkg::MIN_FRAME_BITS;
    end else if (n > urx_pkg::MAX_FRAME_BITS) begin
      clamp_bits = urx_pkg::MAX_FRAME_BITS;
    end else begin
      clamp_bits = n;
    end
  endfunction : clamp_bits

  // ----------------------------------------------------------------
  // line synchroniser
  // ----------------------------------------------------------------
  logic line_s;

  urx_sync u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_line(i_rx_line),
    .o_line(line_s)
  );

  // ----------------------------------------------------------------
  // oversample tick
  // ----------------------------------------------------------------
  logic [11:0] div_cnt;
  logic [11:0] next_div_cnt;
  logic tick;
  logic next_tick;

  // one tick per divisor+1 clocks; samples per bit set the final division
  always_comb begin
    next_tick = (div_cnt == i_baud_divisor_value);
    next_div_cnt = next_tick ? 12'h000 : div_cnt + 12'h001;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_cnt <= 12'h000;
      tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick <= next_tick;
    end
  end

  // ----------------------------------------------------------------
  // recovery state machine
  // ----------------------------------------------------------------
  urx_pkg::urx_state_type state;
  urx_pkg::urx_state_type next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [2:0] win;
  logic [2:0] next_win;
  logic prev;
  logic next_prev;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [3:0] nbits;
  logic [3:0] next_nbits;
  logic [9:0] shift;
  logic [9:0] next_shift;
  logic dbl;
  logic next_dbl;
  logic next_frame_valid;
  logic [9:0] next_frame_data;
  logic next_frame_error_flag;
  logic next_busy;
  logic [4:0] spb;
  logic [4:0] vote_last;
  logic [2:0] samples;
  logic vote;

  // mode is captured per frame so a change mid-frame cannot tear timing
  assign spb = dbl ? urx_pkg::DOUBLE_SPB : urx_pkg::NORMAL_SPB;
  assign vote_last = (dbl ? urx_pkg::DOUBLE_VOTE_FIRST : urx_pkg::NORMAL_VOTE_FIRST)
                     + urx_pkg::VOTE_SPAN;
  assign samples = {win[1:0], line_s};
  assign vote = majority(samples);

  // next-state logic; everything advances only on a sample tick
  // cnt numbers the sample taken at the current tick, so the vote
  // window {win[1:0], line_s} at cnt == vote_last is samples 8-10 (4-6)
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_win = win;
    next_prev = prev;
    next_bit_cnt = bit_cnt;
    next_nbits = nbits;
    next_shift = shift;
    next_dbl = dbl;
    next_frame_valid = 1'b0;
    next_frame_data = o_frame_data;
    next_frame_error_flag = o_frame_error_flag;
    if (tick) begin
      next_win = samples;
      next_prev = line_s;
      next_cnt = (cnt == spb) ? urx_pkg::FIRST_SAMPLE : cnt + 5'h01;
      case (state)
        urx_pkg::ST_IDLE: begin
          next_cnt = cnt;
          if (prev && !line_s) begin
            next_state = urx_pkg::ST_START;
            // the edge tick took sample one, so the next tick takes sample two
            next_cnt = urx_pkg::FIRST_SAMPLE + 5'h01;
            next_dbl = i_double_speed_select;
            next_nbits = clamp_bits(i_frame_bits);
            next_bit_cnt = 4'h0;
            next_shift = 10'h000;
          end
        end
        urx_pkg::ST_START: begin
          if (cnt == vote_last && vote) begin
            next_state = urx_pkg::ST_IDLE;
          end else if (cnt == spb) begin
            next_state = urx_pkg::ST_DATA;
          end
        end
        urx_pkg::ST_DATA: begin
          if (cnt == vote_last) begin
            next_shift[bit_cnt] = vote;
            next_bit_cnt = bit_cnt + 4'h1;
          end
          if (cnt == spb && bit_cnt == nbits) begin
            next_state = urx_pkg::ST_STOP;
          end
        end
        urx_pkg::ST_STOP: begin
          if (cnt == vote_last) begin
            // idle again at once so the next edge is caught early
            next_state = urx_pkg::ST_IDLE;
            next_frame_valid = 1'b1;
            next_frame_data = shift;
            next_frame_error_flag = !vote;
          end
        end
        default: begin
          next_state = urx_pkg::ST_IDLE;
        end
      endcase
    end
    next_busy = (next_state != urx_pkg::ST_IDLE);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= urx_pkg::ST_IDLE;
      cnt <= urx_pkg::FIRST_SAMPLE;
      win <= 3'h7;
      prev <= urx_pkg::LINE_IDLE;
      bit_cnt <= 4'h0;
      nbits <= urx_pkg::MIN_FRAME_BITS;
      shift <= 10'h000;
      dbl <= 1'b0;
      o_frame_valid <= 1'b0;
      o_frame_data <= 10'h000;
      o_frame_error_flag <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      win <= next_win;
      prev <= next_prev;
      bit_cnt <= next_bit_cnt;
      nbits <= next_nbits;
      shift <= next_shift;
      dbl <= next_dbl;
      o_frame_valid <= next_frame_valid;
      o_frame_data <= next_frame_data;
      o_frame_error_flag <= next_frame_error_flag;
      o_busy <= next_busy;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_edge_seen;
    tick && state == urx_pkg::ST_IDLE && prev && !line_s;
  endsequence
  sequence s_start_entered;
    state == urx_pkg::ST_START && cnt == urx_pkg::FIRST_SAMPLE + 5'h01;
  endsequence

  a_edge_starts: assert property (s_edge_seen |=> s_start_entered)
    else $error("falling edge did not start detection");
  a_noise_rejected: assert property (tick && state == urx_pkg::ST_START
      && cnt == vote_last && vote |=> state == urx_pkg::ST_IDLE)
    else $error("noisy start bit was not rejected");
  a_count_range: assert property (cnt >= urx_pkg::FIRST_SAMPLE && cnt <= spb)
    else $error("bit state counter out of range");
  a_counter_wraps: assert property (tick && state != urx_pkg::ST_IDLE
      && cnt == spb |=> cnt == urx_pkg::FIRST_SAMPLE)
    else $error("bit state counter did not wrap");
  a_data_voted: assert property (tick && state == urx_pkg::ST_DATA
      && cnt == vote_last |=> shift[$past(bit_cnt)] == $past(vote))
    else $error("data bit differs from majority");
  a_frame_error: assert property (o_frame_valid
      |-> o_frame_error_flag == !$past(vote))
    else $error("frame error does not match stop vote");
  a_idle_after: assert property (o_frame_valid |-> state == urx_pkg::ST_IDLE
      && !o_busy)
    else $error("receiver not idle after stop vote");
  a_valid_pulse: assert property (o_frame_valid |=> !o_frame_valid)
    else $error("frame valid longer than one cycle");
  a_bits_bound: assert property (bit_cnt <= urx_pkg::MAX_FRAME_BITS)
    else $error("too many bits in one frame");
  a_vote_position: assert property (state != urx_pkg::ST_IDLE
      |-> vote_last == (dbl ? 5'h06 : 5'h0A))
    else $error("vote window misplaced");
endmodule : urx_recovery

`default_nettype wire

/* urx_tx_model.sv */
// behavioural remote serial transmitter that drives the receive line
`timescale 1ns/100ps
`default_nettype none

module urx_tx_model (
  // clock used only to pace bit times
  input wire logic i_clk,
  // serial line towards the receiver
  output logic o_line
);
  // ----------------------------------------------------------------
  // line driver, changes only on falling edges
  // ----------------------------------------------------------------
  initial o_line = 1'b1; // line idles high

  // hold one level for a number of clock cycles
  task automatic hold(input logic lvl, input int clks);
    o_line = lvl;
    repeat (clks) @(negedge i_clk);
  endtask : hold

  // start bit, n bits lsb first, then one stop of a chosen length
  // bit time equals the receiver's nominal bit time, so rate error is zero
  task automatic send(input logic [9:0] data, input int n, input logic stop,
                      input int bit_clks, input int stop_clks);
    hold(1'b0, bit_clks);
    for (int k = 0; k < n; k++) begin
      hold(data[k], bit_clks);
    end
    hold(stop, stop_clks);
    // a low stop leaves the line low; give it one idle bit so the next
    // frame or spike starts from a clean high level
    if (!stop) begin
      hold(1'b1, bit_clks);
    end
  endtask : send
endmodule : urx_tx_model

`default_nettype wire

/* urx_recovery_tb.sv */
// self-checking testbench for the receive clock and data recovery
`timescale 1ns/100ps
`default_nettype none

module urx_recovery_tb;
  localparam logic [11:0] DIV = 12'h0001; // one sample tick every two clocks
  logic i_clk;
  logic i_rst;
  logic ds;
  logic [3:0] nbits;
  wire logic rx_line;
  logic frame_valid;
  logic [9:0] frame_data;
  logic frame_error;
  logic busy;
  int miscompares;
  int total_checks;
  logic [9:0] q_data[$];
  logic [9:0] q_fe[$];

  urx_recovery urx_recovery_i (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_rx_line(rx_line),
    .i_double_speed_select(ds),
    .i_baud_divisor_value(DIV),
    .i_frame_bits(nbits),
    .o_frame_valid(frame_valid),
    .o_frame_data(frame_data),
    .o_frame_error_flag(frame_error),
    .o_busy(busy)
  );

  urx_tx_model urx_tx_model_i (
    .i_clk(i_clk),
    .o_line(rx_line)
  );

  // 125 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // collect handed-over frames; sampled mid-cycle where outputs are settled
  always @(negedge i_clk) begin
    if (frame_valid === 1'b1) begin
      q_data.push_back(frame_data);
      q_fe.push_back({9'h000, frame_error});
    end
  end

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // bounded wait: a frame that never comes ends the run
  task automatic wait_frames(input int cnt);
    int k;
    k = 0;
    while (q_data.size() < cnt && k < 2000) begin
      @(negedge i_clk);
      k++;
    end
    if (q_data.size() < cnt) begin
      miscompares++;
      $display("FAIL frame_count expected %0d seen %0d", cnt, q_data.size());
      end_sim();
    end
  endtask : wait_frames

  task automatic pop_chk(input logic [9:0] exp, input logic fe);
    chk("frame_data", exp, q_data.pop_front());
    chk("frame_error", {9'h000, fe}, q_fe.pop_front());
  endtask : pop_chk

  // nominal bit time in clocks for the current mode
  function automatic int bclk();
    return (ds ? 8 : 16) * (int'(DIV) + 1);
  endfunction : bclk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_normal();
    ds = 1'b0;
    nbits = 4'h8;
    urx_tx_model_i.send(10'h1A5, 8, 1'b1, bclk(), bclk());
    wait_frames(1);
    pop_chk(10'h0A5, 1'b0);
    chk("busy", 10'h000, {9'h000, busy});
  endtask : t_normal

  // double speed, widest frame, stop bit forced low
  task automatic t_double_err();
    ds = 1'b1;
    nbits = 4'hA;
    urx_tx_model_i.send(10'h2C3, 10, 1'b0, bclk(), bclk());
    wait_frames(1);
    pop_chk(10'h2C3, 1'b1);
  endtask : t_double_err

  // low spike far shorter than half a bit must be dropped
  task automatic t_noise();
    ds = 1'b0;
    nbits = 4'h8;
    urx_tx_model_i.hold(1'b0, 6);
    urx_tx_model_i.hold(1'b1, 80);
    chk("frame_count", 10'h000, 10'(q_data.size()));
    chk("busy", 10'h000, {9'h000, busy});
  endtask : t_noise

  // shortest frame; upper bits must read zero
  task automatic t_min();
    nbits = 4'h5;
    urx_tx_model_i.send(10'h3F5, 5, 1'b1, bclk(), bclk());
    wait_frames(1);
    pop_chk(10'h015, 1'b0);
  endtask : t_min

  // next start edge right after the stop vote window, eleven samples of stop
  task automatic t_back();
    nbits = 4'h7;
    urx_tx_model_i.send(10'h05A, 7, 1'b1, bclk(), bclk() * 11 / 16);
    urx_tx_model_i.send(10'h121, 7, 1'b1, bclk(), bclk());
    wait_frames(2);
    pop_chk(10'h05A, 1'b0);
    pop_chk(10'h021, 1'b0);
  endtask : t_back

  // main sequence
  initial begin
    i_rst = 1'b1;
    ds = 1'b0;
    nbits = 4'h8;
    miscompares = 0;
    total_checks = 0;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    t_normal();
    t_double_err();
    t_noise();
    t_min();
    t_back();
    end_sim();
  end
endmodule : urx_recovery_tb

`default_nettype wire
